/* File: common/gpb_pkg.sv */
// Package for the general-purpose pin bank with wake events: map, fields and carriers
package gpb_pkg;

    //------------------------------------------------------------------
    // Sizes
    //------------------------------------------------------------------
    localparam int NPIN  = 22;              // Pins across the four data banks
    localparam int NBANK = 4;
    localparam int AW    = 16;              // Host address width
    localparam int DW    = 8;               // Host data width

    //------------------------------------------------------------------
    // Runtime register offsets from the block base
    //------------------------------------------------------------------
    localparam logic [7:0] DATA_OFS [NBANK] = '{8'h4d, 8'h4e, 8'h4f, 8'h50};
    localparam logic [7:0] WSTS_OFS [NBANK] = '{8'h08, 8'h09, 8'h0a, 8'h0b};
    localparam logic [7:0] WEN_OFS  [NBANK] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f};
    localparam logic [7:0] SEN_OFS  [NBANK] = '{8'h10, 8'h11, 8'h12, 8'h13};
    localparam logic [7:0] GWEN_OFS         = 8'h14;
    localparam logic [7:0] CFG0_OFS         = 8'h23;  // Pin n config at CFG0_OFS + n

    //------------------------------------------------------------------
    // Bank layout: first pin index and number of used bits
    //------------------------------------------------------------------
    localparam int BANK_LO [NBANK] = '{0, 8, 12, 20};
    localparam int BANK_W  [NBANK] = '{8, 4, 8, 2};

    //------------------------------------------------------------------
    // Configuration fields and reset values
    //------------------------------------------------------------------
    localparam int         CFG_DIR   = 0;   // 1 = input, 0 = output
    localparam int         CFG_POL   = 1;   // 1 = inverted
    localparam int         CFG_ODRN  = 7;   // 1 = open drain, 0 = push-pull
    localparam logic [7:0] CFG_RST   = 8'h01;
    localparam int         GWEN_BIT  = 0;

    //------------------------------------------------------------------
    // Pin capabilities
    //------------------------------------------------------------------
    localparam logic [NPIN-1:0] WAKE_MASK  = 22'h3ffaff; // Two bank-D pins cannot wake
    localparam logic [NPIN-1:0] EITHER_EDGE_INTERRUPT_MODE_MASK  = 22'h300a00; // Either-edge capable pins
    localparam logic [NPIN-1:0] NOPOL_MASK = 22'h000800; // Device-disable control pin
    localparam logic [NPIN-1:0] KBC_MASK   = 22'h000000; // Keyboard port-bit pins

    //------------------------------------------------------------------
    // Carriers
    //------------------------------------------------------------------
    typedef struct packed {
        logic          rd;                  // Read strobe, one cycle
        logic          wr;                  // Write strobe, one cycle
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } gpb_req_s;

    typedef struct packed {
        logic [NPIN-1:0] sel;               // Alternate function selected
        logic [NPIN-1:0] either_edge_interrupt_mode;              // Either-edge mode selected
        logic [NPIN-1:0] dout;              // Alternate function drive value
        logic [NPIN-1:0] doe;               // Alternate function wants to drive
    } gpb_alt_s;

endpackage

/* File: rtl/gpb_port_bank.sv */
// General-purpose pin bank with data, config, wake status and event outputs
//
// Overview of operation
// - Config bit 0 picks direction: 0 output, 1 input.
// - Config bit 1 inverts the pin to data path both ways.
// - Config bit 7 picks open drain or push-pull, also for alternate functions.
// - Polarity inverts alternate functions except device-disable control and either-edge mode.
// - Reading an input pin's data bit latches the pin level, maybe inverted.
// - Writing the data bit of an input pin changes nothing.
// - An output pin drives its written data bit, inverted if polarity set.
// - Reading an output pin's data bit returns the last written value.
// - Data banks sit at offsets 4D, 4E, 4F, 50; unused upper bits reserved.
// - Keyboard port-bit alternate functions make the pin bidirectional.
// - Polarity picks the wake edge; clear means rising edge sets status.
// - Wake event output needs status, per-pin enable and global enable all set.
// - Writing one clears a wake status bit; writing zero leaves it.
// - Register block decoded at base from config registers 0x60 and 0x61.
// - Wake-capable pins raise a management interrupt when status and enable set.
// - Either-edge pins set status on both edges, even with enable clear.
`timescale 1ns/10ps
`default_nettype none

module gpb_port_bank
    import gpb_pkg::*;
(
    // Clock and reset
    input  wire logic            I_CLK,
    input  wire logic            I_RST,
    // Host register port and block base
    input  wire gpb_req_s        I_REQ,
    input  wire logic [7:0]      I_BASE_HI,
    input  wire logic [7:0]      I_BASE_LO,
    output logic [DW-1:0]        O_RDATA,
    output logic                 O_RVALID,
    // Pins
    input  wire logic [NPIN-1:0] I_PIN,
    output logic [NPIN-1:0]      O_PIN_OUT,
    output logic [NPIN-1:0]      O_PIN_OE,
    // Alternate functions
    input  wire gpb_alt_s        I_ALT,
    output logic [NPIN-1:0]      O_ALT_IN,
    // Events
    output logic                 O_PME,
    output logic                 O_SMI
);

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    logic [NPIN-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, prev_reg;
    logic [NPIN-1:0] filt_next;
    logic [NPIN-1:0] data_reg, data_next;
    logic [7:0]      cfg_reg  [NPIN];
    logic [7:0]      cfg_next [NPIN];
    logic [NPIN-1:0] wsts_reg, wsts_next;
    logic [NPIN-1:0] wen_reg, wen_next;
    logic [NPIN-1:0] sen_reg, sen_next;
    logic            gwen_reg, gwen_next;
    logic [DW-1:0]   rdata_reg, rdata_next;
    logic            rvalid_reg, rvalid_next;
    logic [NPIN-1:0] pout_reg, pout_next;
    logic [NPIN-1:0] poe_reg, poe_next;
    logic [NPIN-1:0] altin_reg, altin_next;
    logic            pme_reg, pme_next;
    logic            smi_reg, smi_next;

    //------------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------------
    logic [AW-1:0] ofs;
    logic          hit;
    logic [7:0]    ofs8;

    // Offset from the base held in the logical device config pair
    assign ofs  = I_REQ.addr - {I_BASE_HI, I_BASE_LO};
    assign hit  = (ofs[AW-1:8] == 8'h00);
    assign ofs8 = ofs[7:0];

    //------------------------------------------------------------------
    // Per-pin views of the configuration
    //------------------------------------------------------------------
    logic [NPIN-1:0] pol, is_out, odrn, either_edge_interrupt_mode_act, alt_pol, rd_val;
    logic [NPIN-1:0] rise, fall, evt;

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            logic val;
            logic drv;
            logic od;
            assign pol[g]      = cfg_reg[g][CFG_POL];
            assign is_out[g]   = ~cfg_reg[g][CFG_DIR];
            assign odrn[g]     = cfg_reg[g][CFG_ODRN];
            // Either-edge mode only exists on capable pins
            assign either_edge_interrupt_mode_act[g] = I_ALT.either_edge_interrupt_mode[g] & EITHER_EDGE_INTERRUPT_MODE_MASK[g];
            assign alt_pol[g]  = pol[g] & ~NOPOL_MASK[g] & ~either_edge_interrupt_mode_act[g];

            // Value seen by a data read: output latch or filtered pin
            assign rd_val[g] = (is_out[g] & ~either_edge_interrupt_mode_act[g] & ~I_ALT.sel[g])
                             ? data_reg[g]
                             : filt_reg[g] ^ pol[g];

            // Drive source: either-edge pins never drive, since direction
            // and driver bits have no effect in that mode
            always_comb begin
                if (either_edge_interrupt_mode_act[g]) begin
                    val = 1'b0;
                    drv = 1'b0;
                end else if (I_ALT.sel[g]) begin
                    val = I_ALT.dout[g] ^ alt_pol[g];
                    drv = KBC_MASK[g] | I_ALT.doe[g];
                end else begin
                    val = data_reg[g] ^ pol[g];
                    drv = is_out[g];
                end
            end

            // Keyboard port bits are wired-and so both ends can pull low
            assign od           = odrn[g] | (KBC_MASK[g] & I_ALT.sel[g]);
            assign pout_next[g] = od ? 1'b0 : val;
            assign poe_next[g]  = drv & (~od | ~val);
        end
    endgenerate

    //------------------------------------------------------------------
    // Edge selection for wake status
    //------------------------------------------------------------------
    assign rise = filt_reg & ~prev_reg;
    assign fall = ~filt_reg & prev_reg;
    // Polarity clear means rising edge; either-edge pins take both
    assign evt  = WAKE_MASK & ((either_edge_interrupt_mode_act & (rise | fall))
                             | (~either_edge_interrupt_mode_act & ~pol & rise)
                             | (~either_edge_interrupt_mode_act & pol & fall));

    //------------------------------------------------------------------
    // Pin input filter: a change counts once stages two and three agree
    //------------------------------------------------------------------
    assign filt_next = (~(sync2_reg ^ sync3_reg) & sync3_reg)
                     | ((sync2_reg ^ sync3_reg) & filt_reg);

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            filt_reg  <= '0;
            prev_reg  <= '0;
        end else begin
            sync1_reg <= I_PIN;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= filt_next;
            prev_reg  <= filt_reg;
        end
    end

    //------------------------------------------------------------------
    // Register writes, status update and read mux
    //------------------------------------------------------------------
    always_comb begin
        logic [NPIN-1:0] clr;
        logic [NPIN-1:0] bank_src;
        logic [DW-1:0]   rd;
        int              p;
        clr         = '0;
        bank_src    = '0;
        rd          = '0;
        p           = 0;
        data_next   = data_reg;
        cfg_next    = cfg_reg;
        wen_next    = wen_reg;
        sen_next    = sen_reg;
        gwen_next   = gwen_reg;
        rdata_next  = rdata_reg;
        rvalid_next = I_REQ.rd & hit;

        // Banked registers; bits past the bank width are reserved
        for (int b = 0; b < NBANK; b++) begin
            for (int j = 0; j < BANK_W[b]; j++) begin
                p = BANK_LO[b] + j;
                if (I_REQ.wr && hit && ofs8 == DATA_OFS[b] && is_out[p]) begin
                    data_next[p] = I_REQ.wdata[j];
                end
                if (I_REQ.wr && hit && ofs8 == WSTS_OFS[b]) begin
                    clr[p] = I_REQ.wdata[j];
                end
                if (I_REQ.wr && hit && ofs8 == WEN_OFS[b]) begin
                    wen_next[p] = I_REQ.wdata[j];
                end
                if (I_REQ.wr && hit && ofs8 == SEN_OFS[b]) begin
                    sen_next[p] = I_REQ.wdata[j];
                end
                if (ofs8 == DATA_OFS[b]) begin
                    rd[j] = rd_val[p];
                end else if (ofs8 == WSTS_OFS[b]) begin
                    rd[j] = wsts_reg[p];
                end else if (ofs8 == WEN_OFS[b]) begin
                    rd[j] = wen_reg[p];
                end else if (ofs8 == SEN_OFS[b]) begin
                    rd[j] = sen_reg[p];
                end
            end
        end

        // Per-pin configuration bytes
        for (int q = 0; q < NPIN; q++) begin
            if (ofs8 == CFG0_OFS + 8'(q)) begin
                rd = cfg_reg[q];
                if (I_REQ.wr && hit) begin
                    cfg_next[q] = I_REQ.wdata;
                end
            end
        end

        // Global wake enable
        if (ofs8 == GWEN_OFS) begin
            rd[GWEN_BIT] = gwen_reg;
            if (I_REQ.wr && hit) begin
                gwen_next = I_REQ.wdata[GWEN_BIT];
            end
        end

        // A new edge in the clearing cycle survives the clear
        wsts_next = (wsts_reg & ~clr) | evt;

        // Input level captured at the read itself
        if (I_REQ.rd && hit) begin
            rdata_next = rd;
        end

        altin_next = filt_reg ^ alt_pol;
        pme_next   = gwen_reg & |(wsts_reg & wen_reg);
        smi_next   = |(wsts_reg & sen_reg);
    end

    //------------------------------------------------------------------
    // Register stage
    //------------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            data_reg   <= '0;
            wsts_reg   <= '0;
            wen_reg    <= '0;
            sen_reg    <= '0;
            gwen_reg   <= 1'b0;
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
            pout_reg   <= '0;
            poe_reg    <= '0;
            altin_reg  <= '0;
            pme_reg    <= 1'b0;
            smi_reg    <= 1'b0;
            for (int q = 0; q < NPIN; q++) begin
                cfg_reg[q] <= CFG_RST;
            end
        end else begin
            data_reg   <= data_next;
            cfg_reg    <= cfg_next;
            wsts_reg   <= wsts_next;
            wen_reg    <= wen_next;
            sen_reg    <= sen_next;
            gwen_reg   <= gwen_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            pout_reg   <= pout_next;
            poe_reg    <= poe_next;
            altin_reg  <= altin_next;
            pme_reg    <= pme_next;
            smi_reg    <= smi_next;
        end
    end

    //------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    //------------------------------------------------------------------
    assign O_RDATA   = rdata_reg;
    assign O_RVALID  = rvalid_reg;
    assign O_PIN_OUT = pout_reg;
    assign O_PIN_OE  = poe_reg;
    assign O_ALT_IN  = altin_reg;
    assign O_PME     = pme_reg;
    assign O_SMI     = smi_reg;

endmodule

`default_nettype wire

/* File: verif/gpb_pin_model.sv */
// Board-side pin model: resolves bank drive against the board level
`timescale 1ns/10ps
`default_nettype none
module gpb_pin_model
    import gpb_pkg::*;
(
    // Bank drive
    input  wire logic [NPIN-1:0] i_out,
    input  wire logic [NPIN-1:0] i_oe,
    // Board level and resolved pin
    input  wire logic [NPIN-1:0] i_ext,
    output logic [NPIN-1:0]      o_pin
);
    // A driven pin follows the bank; released pins show the board level
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule
`default_nettype wire

/* File: verif/gpb_port_bank_props.sv */
// Port-level checks of the pin bank
`timescale 1ns/10ps
`default_nettype none
module gpb_port_bank_props
    import gpb_pkg::*;
(
    input wire logic            I_CLK,
    input wire logic            I_RST,
    input wire gpb_req_s        I_REQ,
    input wire logic [7:0]      I_BASE_HI,
    input wire logic [7:0]      I_BASE_LO,
    input wire logic [DW-1:0]   O_RDATA,
    input wire logic            O_RVALID,
    input wire logic [NPIN-1:0] O_PIN_OE,
    input wire logic            O_PME,
    input wire logic            O_SMI
);
    // Offset inside the block; the upper byte must be zero for a hit
    logic [AW-1:0] ofs;
    logic          hit;
    assign ofs = I_REQ.addr - {I_BASE_HI, I_BASE_LO};
    assign hit = (ofs[15:8] == 8'h00);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    rd_answer_a: assert property (I_REQ.rd && hit |=> O_RVALID)
        else $error("read hit gave no valid");
    valid_cause_a: assert property (O_RVALID |-> $past(I_REQ.rd && hit))
        else $error("valid without a read hit");
    rdata_hold_a: assert property (!$stable(O_RDATA) |-> O_RVALID)
        else $error("read data moved without a read");
    resv_bankd_a: assert property (I_REQ.rd && hit && ofs[7:0] == 8'h4e |=>
        O_RDATA[7:4] == 4'h0) else $error("bank D reserved bits set");
    resv_bankf_a: assert property (I_REQ.rd && hit && ofs[7:0] == 8'h50 |=>
        O_RDATA[7:2] == 6'h00) else $error("bank F reserved bits set");
    unmapped_zero_a: assert property (I_REQ.rd && hit && ofs[7:0] == 8'h40 |=>
        O_RDATA == 8'h00) else $error("unmapped offset not zero");
    reset_idle_a: assert property ($fell(I_RST) |-> O_PIN_OE == '0 && !O_PME)
        else $error("pins driven after reset");
    gwen_gate_a: assert property (I_REQ.wr && hit && ofs[7:0] == GWEN_OFS
        && !I_REQ.wdata[GWEN_BIT] |-> ##[1:2] !O_PME) else $error("wake not gated");
    cover property (O_PME);
    cover property (O_SMI);
    cover property (O_RVALID ##1 O_RVALID);
endmodule
bind gpb_port_bank gpb_port_bank_props props_u (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_REQ(I_REQ), .I_BASE_HI(I_BASE_HI), .I_BASE_LO(I_BASE_LO), .O_RDATA(O_RDATA),
    .O_RVALID(O_RVALID), .O_PIN_OE(O_PIN_OE), .O_PME(O_PME), .O_SMI(O_SMI));
`default_nettype wire

/* File: verif/tb_gpb_port_bank.sv */
// Self-checking bench for the pin bank
`timescale 1ns/10ps
`default_nettype none
module tb_gpb_port_bank
    import gpb_pkg::*;
;
    localparam logic [15:0] BASE = 16'h0a00;
    logic            clk;
    logic            rst;
    gpb_req_s        req;
    gpb_alt_s        alt;
    logic [DW-1:0]   rdata;
    logic [DW-1:0]   e_q;
    logic [DW-1:0]   d;
    logic            rvalid;
    logic            power_management_event;
    logic            system_management_interrupt;
    logic [NPIN-1:0] pin;
    logic [NPIN-1:0] pout;
    logic [NPIN-1:0] poe;
    logic [NPIN-1:0] ain;
    logic [NPIN-1:0] ext;
    logic [DW-1:0]   expq[$];
    logic [16:0]     lfsr;
    int              n_fail;
    int              num_checks;
    int              cyc;
    `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
        $display("FAIL %s exp %h got %h", nm, e, g); end end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    gpb_port_bank dut_u (.I_CLK(clk), .I_RST(rst), .I_REQ(req), .I_BASE_HI(BASE[15:8]),
        .I_BASE_LO(BASE[7:0]), .O_RDATA(rdata), .O_RVALID(rvalid), .I_PIN(pin),
        .O_PIN_OUT(pout), .O_PIN_OE(poe), .I_ALT(alt), .O_ALT_IN(ain), .O_PME(power_management_event),
        .O_SMI(system_management_interrupt));
    gpb_pin_model model_u (.i_out(pout), .i_oe(poe), .i_ext(ext), .o_pin(pin));
    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    function automatic logic [16:0] nx(input logic [16:0] x);
        return {x[15:0], x[16] ^ x[13]};
    endfunction
    function automatic logic [7:0] bank(input logic [NPIN-1:0] v, input int b);
        return 8'(v >> BANK_LO[b]) & 8'((1 << BANK_W[b]) - 1);
    endfunction
    // One strobe cycle then one idle cycle, so strobes never merge
    task automatic acc(input logic r, input logic w, input logic [15:0] o, input logic [7:0] v);
        @(negedge clk);
        req.rd = r;
        req.wr = w;
        req.addr = BASE + o;
        req.wdata = v;
        @(negedge clk);
        req.rd = 1'b0;
        req.wr = 1'b0;
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] v);
        acc(1'b0, 1'b1, {8'h00, o}, v);
    endtask
    task automatic rd(input logic [7:0] o, input logic [7:0] e);
        expq.push_back(e);
        acc(1'b1, 1'b0, {8'h00, o}, 8'h00);
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Answer monitor and hang guard; a stray answer has no note to match.
    // Sampled on the falling edge so the answer is settled, not racing its launch
    always @(negedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            n_fail++;
            print_verdict();
        end
        if (rvalid === 1'b1) begin
            e_q = (expq.size() > 0) ? expq.pop_front() : 8'hxx;
            `CHK("rdata", e_q, rdata)
        end
    end
    //------------------------------------------------------------------
    // Sequence
    //------------------------------------------------------------------
    initial begin
        req = '0;
        alt = '0;
        ext = '0;
        rst = 1'b1;
        lfsr = 17'h180b1;
        n_fail = 0;
        num_checks = 0;
        cyc = 0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rd(CFG0_OFS, 8'h01);
        rd(8'h40, 8'h00);
        acc(1'b1, 1'b0, 16'h0140, 8'h00);
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < NPIN; k++) wr(CFG0_OFS + 8'(k), {6'h00, p[0], 1'b1});
            lfsr = nx(lfsr);
            ext = {lfsr[4:0], lfsr};
            wr(DATA_OFS[0], 8'h5a);
            repeat (8) @(negedge clk);
            `CHK("alt_in", ext ^ ({NPIN{p[0]}} & ~NOPOL_MASK), ain)
            for (int b = 0; b < NBANK; b++) rd(DATA_OFS[b], bank(ext ^ {NPIN{p[0]}}, b));
        end
        $display("test inputs done");
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 8; k++) wr(CFG0_OFS + 8'(k), {m[1], 5'h00, m[0], 1'b0});
            lfsr = nx(lfsr);
            wr(DATA_OFS[0], lfsr[7:0]);
            repeat (2) @(negedge clk);
            d = lfsr[7:0] ^ {8{m[0]}};
            `CHK("pin_out", m[1] ? 8'h00 : d, pout[7:0])
            `CHK("pin_oe", m[1] ? ~d : 8'hff, poe[7:0])
            rd(DATA_OFS[0], lfsr[7:0]);
        end
        $display("test outputs done");
        for (int k = 0; k < NPIN; k++) wr(CFG0_OFS + 8'(k), 8'h01);
        ext = '0;
        repeat (8) @(negedge clk);
        for (int b = 0; b < NBANK; b++) wr(WSTS_OFS[b], 8'hff);
        rd(WSTS_OFS[0], 8'h00);
        wr(WEN_OFS[0], 8'h01);
        wr(GWEN_OFS, 8'h01);
        ext[0] = 1'b1;
        repeat (10) @(negedge clk);
        `CHK("pme", 1'b1, power_management_event)
        `CHK("smi_off", 1'b0, system_management_interrupt)
        wr(WSTS_OFS[0], 8'h00);
        rd(WSTS_OFS[0], 8'h01);
        wr(SEN_OFS[0], 8'h01);
        wr(GWEN_OFS, 8'h00);
        repeat (2) @(negedge clk);
        `CHK("pme_gated", 1'b0, power_management_event)
        `CHK("smi_on", 1'b1, system_management_interrupt)
        wr(CFG0_OFS, 8'h03);
        for (int t = 0; t < 2; t++) begin
            wr(WSTS_OFS[0], 8'h01);
            ext[0] = ~ext[0];
            repeat (10) @(negedge clk);
            rd(WSTS_OFS[0], {7'h00, ~ext[0]});
        end
        alt.either_edge_interrupt_mode[9] = 1'b1;
        for (int t = 0; t < 2; t++) begin
            wr(WSTS_OFS[1], 8'hff);
            ext[9:8] = ~ext[9:8];
            repeat (10) @(negedge clk);
            rd(WSTS_OFS[1], 8'h02);
        end
        repeat (4) @(negedge clk);
        `CHK("answers_left", 0, expq.size())
        $display("test wake done");
        print_verdict();
    end
endmodule
`default_nettype wire
